// ---- serial_front_pkg.sv ----
// constants for the serial line front end: register map, reset values,
// character codes and loopback timing
// assumes a 10 MHz system clock and a byte-wide UART underneath
package serial_front_pkg;
  // register offsets (byte addresses)
  localparam logic [3:0]  CTRL_OFS       = 4'h0;
  localparam logic [3:0]  BAUD_OFS       = 4'h4;
  localparam logic [3:0]  STAT_OFS       = 4'h8;
  // control field positions
  localparam int          ECHO_BIT       = 0;
  localparam int          PROMPT_BIT     = 1;
  localparam int          XON_BIT        = 2;
  localparam int          LBSTART_BIT    = 3;
  // status field positions
  localparam int          LBDONE_BIT     = 0;
  localparam int          LBPASS_BIT     = 1;
  localparam int          BUSY_BIT       = 2;
  localparam int          CNT_LSB        = 8;
  // values after reset: 9600 8N1, echo on, pacing off, no prompt
  localparam logic        ECHO_RST       = 1'b1;
  localparam logic        PROMPT_RST     = 1'b0;
  localparam logic        XON_RST        = 1'b0;
  localparam logic [14:0] BAUD_RST       = 15'h2580;
  // character codes
  localparam logic [7:0]  CH_BS          = 8'h08;
  localparam logic [7:0]  CH_LF          = 8'h0A;
  localparam logic [7:0]  CH_CR          = 8'h0D;
  localparam logic [7:0]  CH_XON         = 8'h11;
  localparam logic [7:0]  CH_XOFF        = 8'h13;
  localparam logic [7:0]  CH_SP          = 8'h20;
  localparam logic [7:0]  CH_GT          = 8'h3E;
  localparam logic [7:0]  LB_PATTERN     = 8'h55;
  // line buffer depth in characters
  localparam logic [6:0]  LINE_DEPTH     = 7'h40;
  // loopback wait: time in microseconds, then cycles at the clock rate
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          LB_TIMEOUT_US  = 5000;
  localparam int          LB_TIMEOUT_CYC = LB_TIMEOUT_US * (CLK_HZ / 1_000_000);
  // transmit buffer shape
  localparam int          TXBUF_DEPTH    = 2;
endpackage : serial_front_pkg

// ---- tx_pair_buffer.sv ----
// two-entry byte buffer between the echo logic and the UART transmitter
// assumes both sides on clk; head entry feeds the output directly
`timescale 1ns/1ns
module tx_pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = serial_front_pkg::TXBUF_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // draining side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] ent_ff [DEPTH];
  logic [WIDTH-1:0] nxt_ent [DEPTH];
  logic [CW-1:0]    cnt_ff;
  logic [CW-1:0]    nxt_cnt;
  logic             push;
  logic             pop;
  logic [CW-1:0]    wpos;

  assign push = inValid & inReady;
  assign pop  = outValid & outReady;
  assign wpos = pop ? cnt_ff - CW'(1) : cnt_ff;

  // shift toward the head on pop, write at the first free slot on push
  always_comb begin
    nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
    for (int i = 0; i < DEPTH; i++) begin
      nxt_ent[i] = ent_ff[i];
      if (pop && i + 1 < DEPTH) begin
        nxt_ent[i] = ent_ff[i + 1];
      end
      if (push && wpos == CW'(i)) begin
        nxt_ent[i] = inData;
      end
    end
  end

  always_ff @(posedge clk) begin
    ent_ff <= nxt_ent;
    if (srst) begin
      cnt_ff   <= '0;
      outValid <= 1'b0;
      inReady  <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      outValid <= nxt_cnt != '0;
      inReady  <= nxt_cnt != CW'(DEPTH);
    end
  end

  assign outData = ent_ff[0];
endmodule : tx_pair_buffer

// ---- serial_line_front.sv ----
// serial command port front end: echo, line editing, prompt and
// XON/XOFF pacing, loopback self-test
// assumes a UART on clk that hands over received bytes and takes bytes
// to send, and a command parser that signals when a line is handled
//
// Functional notes
// - echo ordinary characters unchanged when echo on
// - backspace echoes as backspace, space, backspace
// - CR/LF pair echoes only the first
// - prompt mode sends CR LF > after parsing
// - pacing: line end answers XOFF CR, or XOFF
// - after XOFF, send CR LF if echo on
// - loopback self-test passes only if data returns
// - CR or LF ends line, hands to parser
// - backspace removes last stored character
// - parsed line answered with CR LF, except with pacing on and echo off
// - reset: 9600 8N1, echo on, pacing off
`timescale 1ns/1ns
module serial_line_front #(
  parameter int unsigned LB_TIMEOUT = serial_front_pkg::LB_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  // received bytes from the UART
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  output logic             rxReady,
  // bytes to the UART transmitter
  output logic             txValid,
  output logic [7:0]       txData,
  input  wire logic        txReady,
  // line to the command parser
  output logic             lineValid,
  output logic [7:0]       lineData,
  output logic             lineEnd,
  input  wire logic        parseDone,
  // UART setting
  output logic [14:0]      baudRate
);
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SEND   = 5'h02,
    ST_DRAIN  = 5'h04,
    ST_WAIT   = 5'h08,
    ST_LBWAIT = 5'h10
  } state_t;

  state_t          state_ff, nxt_state, ret_ff, nxt_ret;
  logic [3:0][7:0] seq_ff, nxt_seq;
  logic [2:0]      seqLen_ff, nxt_seqLen, seqIdx_ff, nxt_seqIdx;
  logic [7:0]      lineMem [64];
  logic [6:0]      lineCnt_ff, nxt_lineCnt, rdIdx_ff, nxt_rdIdx;
  logic [7:0]      lastTerm_ff, nxt_lastTerm;
  logic [16:0]     lbCnt_ff, nxt_lbCnt;
  logic            lbDone_ff, nxt_lbDone, lbPass_ff, nxt_lbPass;
  logic            lbStart_ff, nxt_lbStart;
  logic            echo_ff, prompt_ff, xon_ff, nxt_echo, nxt_prompt, nxt_xon;
  logic [14:0]     nxt_baud;
  logic [31:0]     nxt_rdata;
  logic            rxReady_ff, lineValid_ff, lineEnd_ff;
  logic            nxt_lineValid, nxt_lineEnd;
  logic [7:0]      lineData_ff, nxt_lineData;
  logic            memWe, rxTake, isTerm, isCtrl, pushValid, pushReady;
  logic [7:0]      pushData;

  assign rxTake = rxValid & rxReady_ff;
  assign isTerm = rxData == serial_front_pkg::CH_CR || rxData == serial_front_pkg::CH_LF;
  assign isCtrl = rxData < serial_front_pkg::CH_SP;
  assign pushValid = state_ff == ST_SEND;
  assign pushData  = seq_ff[seqIdx_ff[1:0]];

  // main sequencing: receive, echo, hand over, answer, self-test
  always_comb begin
    logic [2:0] n;
    n = 3'h0;
    nxt_state = state_ff; nxt_ret = ret_ff; nxt_seq = seq_ff;
    nxt_seqLen = seqLen_ff; nxt_seqIdx = seqIdx_ff;
    nxt_lineCnt = lineCnt_ff; nxt_rdIdx = rdIdx_ff; nxt_lastTerm = lastTerm_ff;
    nxt_lbCnt = lbCnt_ff; nxt_lbDone = lbDone_ff; nxt_lbPass = lbPass_ff;
    nxt_lbStart = lbStart_ff;
    nxt_lineValid = 1'b0; nxt_lineEnd = 1'b0; nxt_lineData = lineData_ff;
    memWe = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (lbStart_ff) begin
          nxt_lbStart = 1'b0; // self-test sends one pattern byte
          nxt_seq = {24'h000000, serial_front_pkg::LB_PATTERN};
          nxt_seqLen = 3'h1; nxt_ret = ST_LBWAIT;
          nxt_lbCnt = '0; nxt_lbDone = 1'b0; nxt_lbPass = 1'b0;
          nxt_state = ST_SEND;
        end else if (rxTake) begin
          nxt_ret = ST_IDLE; nxt_seqLen = 3'h0; nxt_lastTerm = 8'h00;
          if (isTerm && lastTerm_ff != 8'h00 && rxData != lastTerm_ff) begin
            nxt_seqLen = 3'h0; // second of a CR/LF pair is swallowed
          end else if (isTerm) begin
            nxt_lastTerm = rxData;
            nxt_ret = ST_DRAIN; nxt_rdIdx = '0; // terminator ends the line
            if (xon_ff) begin
              nxt_seq = {16'h0000, serial_front_pkg::CH_CR, serial_front_pkg::CH_XOFF};
              nxt_seqLen = echo_ff ? 3'h2 : 3'h1;
            end else if (echo_ff) begin
              nxt_seq = {24'h000000, rxData}; nxt_seqLen = 3'h1;
            end
          end else if (rxData == serial_front_pkg::CH_BS) begin
            if (lineCnt_ff != '0) nxt_lineCnt = lineCnt_ff - 7'h01;
            nxt_seq = {8'h00, serial_front_pkg::CH_BS, serial_front_pkg::CH_SP,
                       serial_front_pkg::CH_BS};
            nxt_seqLen = echo_ff ? 3'h3 : 3'h0;
          end else if (!isCtrl) begin
            if (lineCnt_ff != serial_front_pkg::LINE_DEPTH) begin
              memWe = 1'b1; nxt_lineCnt = lineCnt_ff + 7'h01;
            end
            nxt_seq = {24'h000000, rxData};
            nxt_seqLen = echo_ff ? 3'h1 : 3'h0;
          end // remaining control codes drop out here
          if (nxt_seqLen != 3'h0) nxt_state = ST_SEND;
          else nxt_state = nxt_ret;
          nxt_seqIdx = 3'h0;
        end
      end
      ST_SEND: begin
        if (pushReady) begin
          if (seqIdx_ff == seqLen_ff - 3'h1) begin
            nxt_seqIdx = 3'h0; nxt_state = ret_ff;
          end else begin
            nxt_seqIdx = seqIdx_ff + 3'h1;
          end
        end
      end
      ST_DRAIN: begin
        if (rdIdx_ff == lineCnt_ff) begin
          nxt_lineEnd = 1'b1; nxt_state = ST_WAIT;
        end else begin
          nxt_lineValid = 1'b1; nxt_lineData = lineMem[rdIdx_ff[5:0]];
          nxt_rdIdx = rdIdx_ff + 7'h01;
        end
      end
      ST_WAIT: begin
        if (parseDone) begin
          nxt_lineCnt = '0; nxt_seq = '0;
          if (echo_ff || !xon_ff) begin
            nxt_seq[0] = serial_front_pkg::CH_CR;
            nxt_seq[1] = serial_front_pkg::CH_LF;
            n = 3'h2;
          end
          if (prompt_ff) begin
            nxt_seq[n[1:0]] = serial_front_pkg::CH_GT; n = n + 3'h1;
          end
          if (xon_ff) begin
            nxt_seq[n[1:0]] = serial_front_pkg::CH_XON; n = n + 3'h1;
          end
          nxt_seqLen = n; nxt_seqIdx = 3'h0; nxt_ret = ST_IDLE;
          nxt_state = (n != 3'h0) ? ST_SEND : ST_IDLE;
        end
      end
      ST_LBWAIT: begin
        nxt_lbCnt = lbCnt_ff + 17'h00001;
        if (rxTake) begin
          nxt_lbDone = 1'b1; nxt_state = ST_IDLE;
          nxt_lbPass = rxData == serial_front_pkg::LB_PATTERN;
        end else if (lbCnt_ff == 17'(LB_TIMEOUT - 1)) begin
          nxt_lbDone = 1'b1; nxt_lbPass = 1'b0; nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (regWr && regAddr == serial_front_pkg::CTRL_OFS && regWdata[serial_front_pkg::LBSTART_BIT])
      nxt_lbStart = 1'b1; // a fresh start request wins over its own take
  end

  always_ff @(posedge clk) begin
    if (memWe) lineMem[lineCnt_ff[5:0]] <= rxData;
    if (srst) begin
      state_ff <= ST_IDLE; ret_ff <= ST_IDLE; seq_ff <= '0;
      seqLen_ff <= '0; seqIdx_ff <= '0; lineCnt_ff <= '0; rdIdx_ff <= '0;
      lastTerm_ff <= '0; lbCnt_ff <= '0; lbDone_ff <= 1'b0; lbPass_ff <= 1'b0;
      lbStart_ff <= 1'b0; rxReady_ff <= 1'b0;
      lineValid_ff <= 1'b0; lineEnd_ff <= 1'b0; lineData_ff <= '0;
    end else begin
      state_ff <= nxt_state; ret_ff <= nxt_ret; seq_ff <= nxt_seq;
      seqLen_ff <= nxt_seqLen; seqIdx_ff <= nxt_seqIdx;
      lineCnt_ff <= nxt_lineCnt; rdIdx_ff <= nxt_rdIdx;
      lastTerm_ff <= nxt_lastTerm; lbCnt_ff <= nxt_lbCnt;
      lbDone_ff <= nxt_lbDone; lbPass_ff <= nxt_lbPass; lbStart_ff <= nxt_lbStart;
      rxReady_ff <= (nxt_state == ST_IDLE && !nxt_lbStart) || nxt_state == ST_LBWAIT;
      lineValid_ff <= nxt_lineValid; lineEnd_ff <= nxt_lineEnd;
      lineData_ff <= nxt_lineData;
    end
  end

  // register port: writes and one-cycle-late read data
  always_comb begin
    nxt_echo = echo_ff; nxt_prompt = prompt_ff; nxt_xon = xon_ff;
    nxt_baud = baudRate; nxt_rdata = 32'h00000000;
    if (regWr && regAddr == serial_front_pkg::CTRL_OFS) begin
      nxt_echo   = regWdata[serial_front_pkg::ECHO_BIT];
      nxt_prompt = regWdata[serial_front_pkg::PROMPT_BIT];
      nxt_xon    = regWdata[serial_front_pkg::XON_BIT];
    end
    if (regWr && regAddr == serial_front_pkg::BAUD_OFS) nxt_baud = regWdata[14:0];
    if (regRd) begin
      case (regAddr)
        serial_front_pkg::CTRL_OFS: begin
          nxt_rdata[serial_front_pkg::ECHO_BIT]    = echo_ff;
          nxt_rdata[serial_front_pkg::PROMPT_BIT]  = prompt_ff;
          nxt_rdata[serial_front_pkg::XON_BIT]     = xon_ff;
          nxt_rdata[serial_front_pkg::LBSTART_BIT] = lbStart_ff;
        end
        serial_front_pkg::BAUD_OFS: nxt_rdata[14:0] = baudRate;
        serial_front_pkg::STAT_OFS: begin
          nxt_rdata[serial_front_pkg::LBDONE_BIT] = lbDone_ff;
          nxt_rdata[serial_front_pkg::LBPASS_BIT] = lbPass_ff;
          nxt_rdata[serial_front_pkg::BUSY_BIT]   = state_ff != ST_IDLE;
          nxt_rdata[serial_front_pkg::CNT_LSB +: 7] = lineCnt_ff;
        end
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      echo_ff   <= serial_front_pkg::ECHO_RST;
      prompt_ff <= serial_front_pkg::PROMPT_RST;
      xon_ff    <= serial_front_pkg::XON_RST;
      baudRate  <= serial_front_pkg::BAUD_RST;
      regRdata  <= 32'h00000000;
    end else begin
      echo_ff <= nxt_echo; prompt_ff <= nxt_prompt; xon_ff <= nxt_xon;
      baudRate <= nxt_baud; regRdata <= nxt_rdata;
    end
  end

  // outgoing bytes pass the two-entry buffer, which stalls SEND when full
  tx_pair_buffer #(.WIDTH(8), .DEPTH(serial_front_pkg::TXBUF_DEPTH)) u_txbuf (
    .clk      (clk),
    .srst     (srst),
    .inValid  (pushValid),
    .inData   (pushData),
    .inReady  (pushReady),
    .outValid (txValid),
    .outData  (txData),
    .outReady (txReady)
  );

  assign rxReady   = rxReady_ff;
  assign lineValid = lineValid_ff;
  assign lineData  = lineData_ff;
  assign lineEnd   = lineEnd_ff;

  // checks on the sequencing
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire idleTake = state_ff == ST_IDLE && !lbStart_ff && rxTake;

  echo_char_a: assert property (idleTake && !isCtrl && echo_ff
    |=> state_ff == ST_SEND && seqLen_ff == 3'h1 && seq_ff[0] == $past(rxData))
    else $error("ordinary character not echoed");
  bs_echo_a: assert property (idleTake && rxData == serial_front_pkg::CH_BS && echo_ff
    |=> seqLen_ff == 3'h3 && seq_ff[1] == serial_front_pkg::CH_SP)
    else $error("backspace echo wrong");
  pair_swallow_a: assert property (idleTake && isTerm && lastTerm_ff != 8'h00
    && rxData != lastTerm_ff |=> state_ff == ST_IDLE && lastTerm_ff == 8'h00)
    else $error("second terminator echoed");
  prompt_seq_a: assert property (state_ff == ST_WAIT && parseDone && prompt_ff
    && !xon_ff |=> seqLen_ff == 3'h3 && seq_ff[2] == serial_front_pkg::CH_GT)
    else $error("prompt sequence wrong");
  xoff_first_a: assert property (idleTake && isTerm && xon_ff && lastTerm_ff == 8'h00
    |=> seq_ff[0] == serial_front_pkg::CH_XOFF && seqLen_ff == ($past(echo_ff) ? 3'h2 : 3'h1))
    else $error("line end under pacing not XOFF first");
  crlf_seq_a: assert property (state_ff == ST_WAIT && parseDone && echo_ff
    |=> seq_ff[0] == serial_front_pkg::CH_CR && seq_ff[1] == serial_front_pkg::CH_LF)
    else $error("terminator sequence missing");
  xon_last_a: assert property (state_ff == ST_WAIT && parseDone && xon_ff
    |=> seq_ff[seqLen_ff[1:0] - 2'h1] == serial_front_pkg::CH_XON)
    else $error("resume character missing");
  lb_fail_a: assert property ($rose(lbDone_ff) && !$past(rxTake) |-> !lbPass_ff)
    else $error("self-test passed without returned data");
  bs_remove_a: assert property (idleTake && rxData == serial_front_pkg::CH_BS
    && lineCnt_ff != '0 |=> lineCnt_ff == $past(lineCnt_ff) - 7'h01)
    else $error("backspace did not remove a character");
  ctrl_drop_a: assert property (idleTake && isCtrl && !isTerm
    && rxData != serial_front_pkg::CH_BS |=> state_ff == ST_IDLE && $stable(lineCnt_ff))
    else $error("control character acted upon");
  line_end_a: assert property (state_ff == ST_DRAIN && rdIdx_ff == lineCnt_ff
    |=> lineEnd_ff && state_ff == ST_WAIT)
    else $error("line not handed over");
endmodule : serial_line_front

// ---- host_link_model.sv ----
// host computer model on the far side of the UART byte streams
// assumes the bench fills sendQ and reads gotQ; single clock clk
`timescale 1ns/1ns
module host_link_model (
  // clock
  input  wire logic       clk,
  // bytes toward the block
  output logic            rxValid,
  output logic [7:0]      rxData,
  input  wire logic       rxReady,
  // bytes from the block
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // behaviour select
  input  wire logic       slow,
  input  wire logic       lbPlug
);
  logic [7:0] sendQ[$];
  logic [7:0] gotQ[$];
  logic       paused;
  logic [1:0] stallCnt;

  // idle line at time zero
  initial begin
    rxValid  = 1'b0;
    rxData   = 8'hA5;
    txReady  = 1'b1;
    paused   = 1'b0;
    stallCnt = 2'h0;
  end

  // sink: collect bytes, stall three cycles in four when slow, track XOFF/XON for the source
  always @(posedge clk) begin
    stallCnt <= stallCnt + 2'h1;
    txReady  <= !slow || (stallCnt == 2'h3);
    if (txValid && txReady) begin
      gotQ.push_back(txData);
      if (txData == serial_front_pkg::CH_XOFF) paused <= 1'b1;
      if (txData == serial_front_pkg::CH_XON) paused <= 1'b0;
      if (lbPlug) sendQ.push_back(txData);                     // plug returns every byte
    end
  end

  // source: hold a byte until taken, then release the line
  always @(posedge clk) begin
    if (rxValid && rxReady) begin
      void'(sendQ.pop_front());
      rxValid <= 1'b0;
      rxData  <= ~rxData;                                       // released line shows no stale byte
    end else if (!rxValid && sendQ.size() > 0 && !paused) begin
      rxValid <= 1'b1;
      rxData  <= sendQ[0];
    end
  end
endmodule : host_link_model

// ---- tb_top.sv ----
// self-checking bench for the serial line front end
// assumes host_link_model on the byte streams; the parser is answered here
`timescale 1ns/1ns
`define CHECK(what, expv, gotv) \
  begin \
    cmpCount++; \
    if ((gotv) !== (expv)) begin \
      errorCnt++; \
      $display("MISMATCH %s expected %0h seen %0h", what, expv, gotv); \
    end \
  end
module tb_top;
  logic        clk;
  logic        srst;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        rxValid;
  logic [7:0]  rxData;
  logic        rxReady;
  logic        txValid;
  logic [7:0]  txData;
  logic        txReady;
  logic        lineValid;
  logic [7:0]  lineData;
  logic        lineEnd;
  logic        parseDone;
  logic [14:0] baudRate;
  logic        slow;
  logic        lbPlug;
  logic [7:0]  lineQ[$];
  int          lineEnds;
  int          doneWait;
  int          cycles;
  int          errorCnt;
  int          cmpCount;

  serial_line_front #(.LB_TIMEOUT(200)) u_serial_line_front (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
    .txValid(txValid), .txData(txData), .txReady(txReady),
    .lineValid(lineValid), .lineData(lineData), .lineEnd(lineEnd),
    .parseDone(parseDone), .baudRate(baudRate));

  host_link_model u_host (
    .clk(clk), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady),
    .txValid(txValid), .txData(txData), .txReady(txReady),
    .slow(slow), .lbPlug(lbPlug));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // parser stand-in answers each line four cycles later; hang guard
  always @(posedge clk) begin
    parseDone <= (doneWait == 1);
    if (doneWait > 0) doneWait <= doneWait - 1;
    if (lineValid) lineQ.push_back(lineData);
    if (lineEnd) begin
      lineEnds++;
      doneWait <= 4;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errorCnt++;
      reportAndStop();
    end
  end

  task automatic reportAndStop();
    $display("TB: %0d comparisons, %0d mismatches", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : reportAndStop

  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr    <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
    @(posedge clk);
  endtask : regRead

  task automatic sendBytes(input logic [7:0] b[$]);
    foreach (b[i]) u_host.sendQ.push_back(b[i]);
  endtask : sendBytes

  // wait for the expected byte count, then allow time for stray extras
  task automatic expectTx(input string what, input logic [7:0] exp[$]);
    int n;
    n = 0;
    while (u_host.gotQ.size() < exp.size() && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(posedge clk);
    `CHECK({what, " count"}, exp.size(), u_host.gotQ.size())
    foreach (exp[i]) begin
      if (i < u_host.gotQ.size()) `CHECK(what, exp[i], u_host.gotQ[i])
    end
    u_host.gotQ.delete();
  endtask : expectTx

  task automatic expectLine(input string what, input logic [7:0] exp[$], input int ends);
    `CHECK({what, " size"}, exp.size(), lineQ.size())
    foreach (exp[i]) begin
      if (i < lineQ.size()) `CHECK(what, exp[i], lineQ[i])
    end
    `CHECK({what, " ends"}, ends, lineEnds)
    lineQ.delete();
    lineEnds = 0;
  endtask : expectLine

  task automatic testReset();
    logic [31:0] d;
    regRead(serial_front_pkg::CTRL_OFS, d);
    `CHECK("ctrl reset", 32'h00000001, d)
    regRead(serial_front_pkg::BAUD_OFS, d);
    `CHECK("baud reset", 32'h00002580, d)
    `CHECK("baud port reset", 15'h2580, baudRate)
    regRead(4'hC, d);
    `CHECK("unmapped read", 32'h00000000, d)
    regWrite(serial_front_pkg::BAUD_OFS, 32'h00004B00);
    regRead(serial_front_pkg::BAUD_OFS, d);
    `CHECK("baud write", 32'h00004B00, d)
    `CHECK("baud port", 15'h4B00, baudRate)
    $display("TB: reset test done");
  endtask : testReset

  task automatic testEcho();
    logic [31:0] d;
    slow <= 1'b1;
    sendBytes('{8'h41, 8'h62, 8'h01});
    expectTx("echo chars", '{8'h41, 8'h62});
    regRead(serial_front_pkg::STAT_OFS, d);
    `CHECK("stored count", 7'h02, d[14:8])
    sendBytes('{8'h08});
    expectTx("bs echo", '{8'h08, 8'h20, 8'h08});
    regRead(serial_front_pkg::STAT_OFS, d);
    `CHECK("count after bs", 7'h01, d[14:8])
    sendBytes('{8'h0D, 8'h0A});
    expectTx("crlf echo", '{8'h0D, 8'h0D, 8'h0A});
    expectLine("line a", '{8'h41}, 1);
    slow <= 1'b0;
    $display("TB: echo test done");
  endtask : testEcho

  task automatic testPrompt();
    regWrite(serial_front_pkg::CTRL_OFS, 32'h00000003);
    sendBytes('{8'h58, 8'h0A, 8'h0D});
    expectTx("prompt one", '{8'h58, 8'h0A, 8'h0D, 8'h0A, 8'h3E});
    expectLine("line x", '{8'h58}, 1);
    sendBytes('{8'h59, 8'h0D});
    expectTx("prompt two", '{8'h59, 8'h0D, 8'h0D, 8'h0A, 8'h3E});
    expectLine("line y", '{8'h59}, 1);
    regWrite(serial_front_pkg::CTRL_OFS, 32'h00000000);
    sendBytes('{8'h52, 8'h0D});
    expectTx("silent line", '{8'h0D, 8'h0A});
    expectLine("line r", '{8'h52}, 1);
    $display("TB: prompt test done");
  endtask : testPrompt

  task automatic testPacing();
    regWrite(serial_front_pkg::CTRL_OFS, 32'h00000005);
    slow <= 1'b1;
    sendBytes('{8'h5A, 8'h0D, 8'h57, 8'h0A});
    expectTx("pace echo", '{8'h5A, 8'h13, 8'h0D, 8'h0D, 8'h0A, 8'h11,
                            8'h57, 8'h13, 8'h0D, 8'h0D, 8'h0A, 8'h11});
    expectLine("pace lines", '{8'h5A, 8'h57}, 2);
    slow <= 1'b0;
    regWrite(serial_front_pkg::CTRL_OFS, 32'h00000004);
    sendBytes('{8'h51, 8'h0D});
    expectTx("quiet pace", '{8'h13, 8'h11});
    expectLine("quiet line", '{8'h51}, 1);
    regWrite(serial_front_pkg::CTRL_OFS, 32'h00000007);
    sendBytes('{8'h41, 8'h0A});
    expectTx("prompt pace", '{8'h41, 8'h13, 8'h0D, 8'h0D,
                              8'h0A, 8'h3E, 8'h11});
    expectLine("prompt pace line", '{8'h41}, 1);
    $display("TB: pacing test done");
  endtask : testPacing

  // each run waits past the 200-cycle loopback limit before reading status
  task automatic testLoop();
    logic [31:0] d;
    lbPlug <= 1'b0;
    regWrite(serial_front_pkg::CTRL_OFS, 32'h00000009);
    repeat (250) @(posedge clk);
    regRead(serial_front_pkg::STAT_OFS, d);
    `CHECK("no plug status", 2'b01, d[1:0])
    expectTx("no plug byte", '{8'h55});
    lbPlug <= 1'b1;
    regWrite(serial_front_pkg::CTRL_OFS, 32'h00000009);
    repeat (250) @(posedge clk);
    regRead(serial_front_pkg::STAT_OFS, d);
    `CHECK("plug status", 2'b11, d[1:0])
    expectTx("plug byte", '{8'h55});
    $display("TB: loopback test done");
  endtask : testLoop

  // reset, then the scenarios in turn
  initial begin
    srst      = 1'b1;
    regAddr   = 4'h0;
    regWdata  = 32'h00000000;
    regWr     = 1'b0;
    regRd     = 1'b0;
    parseDone = 1'b0;
    slow      = 1'b0;
    lbPlug    = 1'b0;
    lineEnds  = 0;
    doneWait  = 0;
    cycles    = 0;
    errorCnt  = 0;
    cmpCount  = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    testReset();
    testEcho();
    testPrompt();
    testPacing();
    testLoop();
    reportAndStop();
  end
endmodule : tb_top
